// File: sod_pkg.sv
// Constants, register map and types for the sync request filter and
// over-range detector.
// Assumes one core clock that also carries the sample rate.
package sod_pkg;
	// Register byte addresses on the device register port
	localparam logic [11:0] SOD_SYNC_LIMIT_ADDR = 12'h210;
	localparam logic [11:0] SOD_OVR_LEVEL_ADDR = 12'h211;
	localparam logic [11:0] SOD_OVERRANGE_CONFIG_ADDR = 12'h213;
	localparam logic [11:0] SOD_INIT_STATUS_ADDR = 12'h270;
	// Reset values
	localparam logic [7:0] SOD_SYNC_LIMIT_RESET = 8'h03;
	localparam logic [7:0] SOD_OVR_LEVEL_RESET = 8'hf2;
	localparam logic [7:0] SOD_OVERRANGE_CONFIG_RESET = 8'h07;
	localparam logic [7:0] SOD_ZERO_BYTE = 8'h00;
	// Field layout
	localparam int SOD_SYNC_LIMIT_W = 5;
	localparam int SOD_OVERRANGE_OUTPUT_ENABLE_BIT = 3;
	localparam int SOD_OVERRANGE_STRETCH_EXPONENT_W = 3;
	localparam int SOD_INIT_DONE_BIT = 0;
	// Timing: shortest stretch is this many samples times 2**exponent
	localparam int SOD_STRETCH_BASE = 4;
	localparam int SOD_STRETCH_CNT_W = 10;
	localparam int SOD_CHANNELS = 4;
	// Initialisation sequencer
	typedef enum logic [1:0] {
		SOD_INIT_BUSY = 2'b01,
		SOD_INIT_READY = 2'b10
	} sod_init_state_t;

	// Shortest high time of an over-range pulse, in sample cycles
	function automatic logic [SOD_STRETCH_CNT_W-1:0] sod_stretch_len(
		input logic [SOD_OVERRANGE_STRETCH_EXPONENT_W-1:0] exponent);
		logic [SOD_STRETCH_CNT_W-1:0] base;
		base = SOD_STRETCH_CNT_W'(SOD_STRETCH_BASE);
		return base << exponent;
	endfunction
endpackage

// File: sod_stretch.sv
// Per-channel over-range pulse stretcher.
// Assumes hit_in is already gated by the output enable in the caller.
`timescale 1ns/10ps
`default_nettype none
module sod_stretch
	import sod_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Control
	input wire logic enable_in,
	input wire logic [SOD_OVERRANGE_STRETCH_EXPONENT_W-1:0] exponent_in,
	// Detection and output
	input wire logic hit_in,
	output logic pulse_out
);
	logic [SOD_STRETCH_CNT_W-1:0] remain;
	logic [SOD_STRETCH_CNT_W-1:0] run;
	logic [SOD_STRETCH_CNT_W-1:0] next_len;

	assign next_len = sod_stretch_len(exponent_in);

	always_ff @(posedge core_clk_in) begin
		if (rst_in || !enable_in) begin
			pulse_out <= 1'b0;
			remain <= '0;
		end else if (hit_in) begin
			// A new hit always reloads the full period
			pulse_out <= 1'b1;
			remain <= next_len - 1'b1;
		end else if (remain != '0) begin
			remain <= remain - 1'b1;
		end else begin
			pulse_out <= 1'b0;
		end
	end

	// Length of the current high run, for checking only
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !pulse_out) begin
			run <= '0;
		end else if (run != '1) begin
			run <= run + 1'b1;
		end
	end

	sequence hit_s;
		enable_in && hit_in;
	endsequence

	disabled_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!enable_in |=> !pulse_out)
		else $error("over-range pin high while disabled");

	min_width_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$fell(pulse_out) && $past(enable_in) && $stable(exponent_in)
		|-> run >= next_len)
		else $error("over-range pulse shorter than stretch period");

	hit_restart_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		hit_s |=> pulse_out && remain == $past(next_len) - 1'b1)
		else $error("stretch counter not restarted by hit");
endmodule
`default_nettype wire

// File: sod_top.sv
// Sync request filter, over-range detection and init status for a
// four-channel converter core.
// Assumes core_clk_in carries one sample per channel per cycle and that
// register accesses arrive already decoded from the serial port.
`timescale 1ns/10ps
`default_nettype none
module sod_top
	import sod_pkg::*;
#(
	parameter int SAMPLE_W = 9,
	parameter int INIT_CYCLES = 64
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [11:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Link synchronisation
	input wire logic sync_n_in,
	input wire logic serial_link_enable_in,
	output logic sync_request_out,
	// Samples, two's complement
	input wire logic [SAMPLE_W-1:0] sample_a_in,
	input wire logic [SAMPLE_W-1:0] sample_b_in,
	input wire logic [SAMPLE_W-1:0] sample_c_in,
	input wire logic [SAMPLE_W-1:0] sample_d_in,
	// Over-range pins
	output logic overrange_out_a,
	output logic overrange_out_b,
	output logic overrange_out_c,
	output logic overrange_out_d
);
	localparam int INIT_W = $clog2(INIT_CYCLES + 1);

	logic [7:0] sync_low_count_limit;
	logic [7:0] overrange_level;
	logic [7:0] overrange_config;
	sod_init_state_t init_state;
	logic [INIT_W-1:0] init_count;
	logic init_ready;
	logic link_tick;
	logic [SOD_SYNC_LIMIT_W-1:0] low_count;
	logic [SOD_SYNC_LIMIT_W-1:0] limit;
	logic overrange_output_enable;
	logic [SOD_OVERRANGE_STRETCH_EXPONENT_W-1:0] overrange_stretch_exponent;
	logic [SAMPLE_W-1:0] samples [SOD_CHANNELS];
	logic [SOD_CHANNELS-1:0] hit;
	logic [SOD_CHANNELS-1:0] pin;

	function automatic logic [SAMPLE_W-1:0] magnitude(
		input logic [SAMPLE_W-1:0] s);
		return s[SAMPLE_W-1] ? SAMPLE_W'(-s) : s;
	endfunction

	assign limit = sync_low_count_limit[SOD_SYNC_LIMIT_W-1:0];
	assign overrange_output_enable = overrange_config[SOD_OVERRANGE_OUTPUT_ENABLE_BIT];
	assign overrange_stretch_exponent = overrange_config[SOD_OVERRANGE_STRETCH_EXPONENT_W-1:0];
	assign init_ready = (init_state == SOD_INIT_READY);

	// Register writes; reserved bits are stored as written
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sync_low_count_limit <= SOD_SYNC_LIMIT_RESET;
			overrange_level <= SOD_OVR_LEVEL_RESET;
			overrange_config <= SOD_OVERRANGE_CONFIG_RESET;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				SOD_SYNC_LIMIT_ADDR: sync_low_count_limit <= reg_wdata_in;
				SOD_OVR_LEVEL_ADDR: overrange_level <= reg_wdata_in;
				SOD_OVERRANGE_CONFIG_ADDR: overrange_config <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Registered read, one cycle late; unmapped addresses read zero
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= SOD_ZERO_BYTE;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				SOD_SYNC_LIMIT_ADDR: reg_rdata_out <= sync_low_count_limit;
				SOD_OVR_LEVEL_ADDR: reg_rdata_out <= overrange_level;
				SOD_OVERRANGE_CONFIG_ADDR: reg_rdata_out <= overrange_config;
				SOD_INIT_STATUS_ADDR: reg_rdata_out <= 8'(init_ready);
				default: reg_rdata_out <= SOD_ZERO_BYTE;
			endcase
		end
	end

	// Initialisation sequencer; accesses are not blocked while busy, the
	// host is expected to poll the status first
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			init_state <= SOD_INIT_BUSY;
			init_count <= '0;
		end else begin
			case (init_state)
				SOD_INIT_BUSY: begin
					if (init_count == INIT_W'(INIT_CYCLES - 1)) begin
						init_state <= SOD_INIT_READY;
					end
					init_count <= init_count + 1'b1;
				end
				SOD_INIT_READY: init_state <= SOD_INIT_READY;
				default: init_state <= SOD_INIT_BUSY;
			endcase
		end
	end

	// Link clock as an enable at half the sample rate
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			link_tick <= 1'b0;
		end else begin
			link_tick <= !link_tick;
		end
	end

	// Low-run filter; a run that ends early just clears the count
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !serial_link_enable_in) begin
			low_count <= '0;
			sync_request_out <= 1'b0;
		end else if (link_tick) begin
			if (sync_n_in) begin
				low_count <= '0;
				sync_request_out <= 1'b0;
			end else if (low_count >= limit) begin
				sync_request_out <= 1'b1;
			end else begin
				low_count <= low_count + 1'b1;
			end
		end
	end

	assign samples[0] = sample_a_in;
	assign samples[1] = sample_b_in;
	assign samples[2] = sample_c_in;
	assign samples[3] = sample_d_in;

	for (genvar ch = 0; ch < SOD_CHANNELS; ch++) begin : g_chan
		assign hit[ch] = overrange_output_enable
			&& (magnitude(samples[ch]) >= SAMPLE_W'(overrange_level));
		sod_stretch u_stretch (
			.core_clk_in(core_clk_in),
			.rst_in(rst_in),
			.enable_in(overrange_output_enable),
			.exponent_in(overrange_stretch_exponent),
			.hit_in(hit[ch]),
			.pulse_out(pin[ch])
		);

		level_hit_a: assert property (@(posedge core_clk_in)
			disable iff (rst_in)
			overrange_output_enable
			&& magnitude(samples[ch]) >= SAMPLE_W'(overrange_level)
			|=> pin[ch])
			else $error("over-range level reached but pin low");
	end

	assign overrange_out_a = pin[0];
	assign overrange_out_b = pin[1];
	assign overrange_out_c = pin[2];
	assign overrange_out_d = pin[3];

	sequence low_tick_s;
		link_tick && !sync_n_in && serial_link_enable_in;
	endsequence

	tick_only_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!$past(link_tick) && serial_link_enable_in
		&& $past(serial_link_enable_in) |-> $stable(sync_request_out))
		else $error("sync request moved off a link tick");

	request_count_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		$rose(sync_request_out) |-> $past(low_count) >= $past(limit)
		&& $past(!sync_n_in))
		else $error("sync request before enough low samples");

	request_take_a: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(low_tick_s and (low_count >= limit)) |=> sync_request_out)
		else $error("sync request not raised at limit");

	short_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		link_tick && sync_n_in |=> !sync_request_out && low_count == '0)
		else $error("released sync input still acted upon");

	init_done_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		init_state == SOD_INIT_BUSY && init_count == INIT_W'(INIT_CYCLES - 1)
		|=> init_ready ##0 $past(!init_ready))
		else $error("init status timing wrong");

	init_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == SOD_INIT_STATUS_ADDR
		|=> reg_rdata_out[SOD_INIT_DONE_BIT] == $past(init_ready))
		else $error("init status read wrong");
endmodule
`default_nettype wire

// File: sod_rx_model.sv
// Link receiver model that drives the active-low sync request line.
// Assumes the bench calls request() from its falling-edge stimulus.
`timescale 1ns/10ps
`default_nettype none
module sod_rx_model (
	// Clock
	input wire logic core_clk_in,
	// Sync line
	output logic sync_n_out
);
	// Idle high: error reports are off, so only requests pull it low
	initial sync_n_out = 1'b1;
	task automatic request(input int cycles);
		@(negedge core_clk_in);
		sync_n_out = 1'b0;
		repeat (cycles) @(negedge core_clk_in);
		sync_n_out = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the sync filter and over-range block.
// Assumes a short init timer and samples shared by all four channels.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sod_pkg::*;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [11:0] reg_addr_in = 12'h000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic sync_n;
	logic link_en = 1'b0;
	logic sync_req;
	logic [8:0] smp = 9'h000;
	logic [3:0] ovr;
	int n_mismatch = 0;
	int checks = 0;
	always #2 core_clk_in = ~core_clk_in;
	sod_top #(.SAMPLE_W(9), .INIT_CYCLES(4)) u_dut (
		.core_clk_in(core_clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .sync_n_in(sync_n),
		.serial_link_enable_in(link_en), .sync_request_out(sync_req),
		.sample_a_in(smp), .sample_b_in(smp), .sample_c_in(smp),
		.sample_d_in(smp), .overrange_out_a(ovr[3]),
		.overrange_out_b(ovr[2]), .overrange_out_c(ovr[1]),
		.overrange_out_d(ovr[0]));
	sod_rx_model u_rx (.core_clk_in(core_clk_in), .sync_n_out(sync_n));
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge core_clk_in);
		reg_wr_in = 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [11:0] a,
		input logic [7:0] exp);
		@(negedge core_clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge core_clk_in);
		reg_rd_in = 1'b0;
		@(negedge core_clk_in);
		chk(what, reg_rdata_out, exp);
	endtask
	// Counts request-high cycles over 2n+8 cycles from the start of a receiver low run
	task automatic sync_run(input int n, output int hits);
		hits = 0;
		fork
			u_rx.request(n);
			repeat (2 * n + 8) begin
				@(negedge core_clk_in);
				hits += int'(sync_req === 1'b1);
			end
		join
	endtask
	// Hit all channels once, optionally again after gap cycles
	task automatic pulse_len(input logic [8:0] v, input int gap,
		output int len);
		len = 0;
		fork
			begin
				@(negedge core_clk_in);
				smp = v;
				@(negedge core_clk_in);
				smp = 9'h000;
				if (gap > 0) begin
					repeat (gap - 1) @(negedge core_clk_in);
					smp = v;
					@(negedge core_clk_in);
					smp = 9'h000;
				end
			end
			repeat (300) begin
				@(negedge core_clk_in);
				len += int'(ovr === 4'hf);
			end
		join
	endtask
	task automatic test_regs();
		rd_chk("init early", SOD_INIT_STATUS_ADDR, 8'h00);
		// Only the status is polled until init reports done
		rd_chk("init done", SOD_INIT_STATUS_ADDR, 8'h01);
		rd_chk("level rst", SOD_OVR_LEVEL_ADDR, 8'hf2);
		rd_chk("cfg rst", SOD_OVERRANGE_CONFIG_ADDR, 8'h07);
		rd_chk("limit rst", SOD_SYNC_LIMIT_ADDR, 8'h03);
		wr(SOD_INIT_STATUS_ADDR, 8'hff);
		rd_chk("init ro", SOD_INIT_STATUS_ADDR, 8'h01);
		rd_chk("unmapped", 12'h212, 8'h00);
		$display("test regs done");
	endtask
	task automatic test_sync();
		int h;
		@(negedge core_clk_in);
		link_en = 1'b1;
		sync_run(6, h);
		chk("short run", 8'(h), 8'h00);
		sync_run(8, h);
		chk("long run", 8'(h > 0), 8'h01);
		chk("req drop", {7'h00, sync_req}, 8'h00);
		// Limit only changes with the link off
		link_en = 1'b0;
		wr(SOD_SYNC_LIMIT_ADDR, 8'h00);
		sync_run(10, h);
		chk("link off", 8'(h), 8'h00);
		link_en = 1'b1;
		sync_run(2, h);
		chk("limit zero", 8'(h > 0), 8'h01);
		$display("test sync done");
	endtask
	task automatic test_ovr();
		int n;
		pulse_len(9'h0f2, 0, n);
		chk("disabled", 8'(n), 8'h00);
		for (int e = 0; e < 3; e++) begin
			wr(SOD_OVERRANGE_CONFIG_ADDR, 8'(8 + e));
			pulse_len(9'h0f2, 0, n);
			chk("stretch", 8'(n), 8'(4 << e));
		end
		wr(SOD_OVERRANGE_CONFIG_ADDR, 8'h08);
		pulse_len(9'h0f1, 0, n);
		chk("below", 8'(n), 8'h00);
		pulse_len(9'h10e, 0, n);
		chk("negative", 8'(n), 8'h04);
		pulse_len(9'h100, 0, n);
		chk("full neg", 8'(n), 8'h04);
		pulse_len(9'h0f2, 2, n);
		chk("retrigger", 8'(n), 8'h06);
		wr(SOD_OVR_LEVEL_ADDR, 8'h80);
		pulse_len(9'h080, 0, n);
		chk("new level", 8'(n), 8'h04);
		wr(SOD_OVERRANGE_CONFIG_ADDR, 8'h0b);
		@(negedge core_clk_in);
		smp = 9'h0f2;
		@(negedge core_clk_in);
		smp = 9'h000;
		chk("on mid", {4'h0, ovr}, 8'h0f);
		wr(SOD_OVERRANGE_CONFIG_ADDR, 8'h03);
		@(negedge core_clk_in);
		chk("off mid", {4'h0, ovr}, 8'h00);
		$display("test ovr done");
	endtask
	initial begin
		repeat (16) @(negedge core_clk_in);
		rst_in = 1'b0;
		test_regs();
		test_sync();
		test_ovr();
		report_and_stop();
	end
endmodule
`default_nettype wire
